// file: sim/psv_core_monitor.sv
// Port checker for the program-space sequencer
`timescale 1ns/100ps
module psv_core_monitor import psv_pkg::*; #(
   parameter int unsigned DEPTH = STACK_DEPTH
)(
   // Clock and reset
   input wire logic            CLK,
   input wire logic            RST_N,
   // Pins and core side
   input wire logic            NMI_N,
   input wire logic            TEST,
   input wire logic            CORE_ADV,
   input wire logic            CORE_JUMP,
   input wire logic            CORE_CALL,
   input wire logic            CORE_RET,
   input wire logic            CORE_IRQ,
   input wire logic [PC_W-1:0] PC_OUT,
   input wire logic            OPCODE_VALID,
   input wire logic            NMI_TAKEN,
   input wire logic            STACK_ERR,
   // Programmer side
   input wire logic            PGM_RD,
   input wire logic            PGM_WR,
   input wire logic            PGM_ERASE,
   input wire logic            PGM_REFUSED,
   input wire logic            PGM_BUSY,
   input wire logic            PROG_MODE,
   input wire logic            PROTECT_ON
);
   logic       ov_q;
   logic [2:0] dep;
   logic       push;
   logic       pop;

   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);

   // Core requests are tracked only the cycle after a fetch; NMI_TAKEN pushes in any cycle
   assign push = (ov_q && (CORE_IRQ || CORE_CALL)) || NMI_TAKEN;
   assign pop  = ov_q && CORE_RET && !CORE_IRQ && !CORE_CALL;

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         ov_q <= 1'b0;
      else
         ov_q <= OPCODE_VALID;
   end

   // Saturates like the stack: a full push overwrites, depth stays
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         dep <= 3'h0;
      else if (push && dep != 3'(DEPTH))
         dep <= dep + 3'h1;
      else if (pop && dep != 3'h0)
         dep <= dep - 3'h1;
   end

   reset_quiet_a: assert property (
      $rose(RST_N) |-> (!OPCODE_VALID && !PROG_MODE) [*3])
      else $error("output active right after reset");
   prog_entry_a: assert property (
      $rose(PROG_MODE) |-> TEST && $past(TEST, 3))
      else $error("programming mode without test level");
   adv_step_a: assert property (
      ov_q && CORE_ADV && !CORE_IRQ && !CORE_CALL && !CORE_RET && !CORE_JUMP
      |=> PC_OUT == $past(PC_OUT) + 12'h001 ##2 OPCODE_VALID)
      else $error("advance did not step the counter");
   irq_entry_a: assert property (
      ov_q && CORE_IRQ |-> ##6 OPCODE_VALID)
      else $error("interrupt entry fetch late");
   nmi_take_a: assert property (
      $fell(NMI_N) |-> ##[2:12] NMI_TAKEN)
      else $error("falling edge not taken");
   ret_empty_a: assert property (
      ov_q && CORE_RET && !CORE_IRQ && !CORE_CALL && dep == 3'h0
      |=> STACK_ERR && $stable(PC_OUT))
      else $error("empty return not flagged");
   read_refuse_a: assert property (
      PROG_MODE && !PGM_BUSY && PGM_RD && !PGM_WR && !PGM_ERASE && PROTECT_ON
      |=> PGM_REFUSED)
      else $error("protected read not refused");
   erase_clear_a: assert property (
      $fell(PROTECT_ON) |-> $past(PGM_BUSY) || $past(PGM_BUSY, 2))
      else $error("protection cleared without erase");
endmodule : psv_core_monitor

// file: sim/psv_core_tb.sv
// Self-checking testbench for the program-space sequencer
`timescale 1ns/100ps
module psv_core_tb import psv_pkg::*; ;
   logic        CLK, RST_N, NMI_N, TEST;
   logic        CORE_ADV, CORE_JUMP, CORE_CALL, CORE_RET, CORE_IRQ;
   logic [11:0] CORE_TARGET, PC_OUT, PGM_ADDR;
   logic [1:0]  CORE_IRQ_SEL;
   logic [7:0]  OPCODE, PGM_WDATA, PGM_RDATA;
   logic        OPCODE_VALID, NMI_TAKEN, STACK_ERR, PGM_WR, PGM_RD;
   logic        PGM_ERASE, PGM_PROTECT, PGM_RVALID, PGM_REFUSED;
   logic        PGM_BUSY, PROG_MODE, PROTECT_ON;
   logic [7:0]  img [4096];
   logic [11:0] pc;
   logic [11:0] stk [$];
   logic [19:0] opq [$];
   logic [8:0]  pgq [$];
   int          mismatches = 0, checks = 0, errs = 0, cyc = 0;

   psv_core u_psv_core (.CLK, .RST_N, .NMI_N, .TEST, .CORE_ADV, .CORE_JUMP,
      .CORE_CALL, .CORE_RET, .CORE_TARGET, .CORE_IRQ, .CORE_IRQ_SEL, .PC_OUT,
      .OPCODE, .OPCODE_VALID, .NMI_TAKEN, .STACK_ERR, .PGM_ADDR, .PGM_WDATA,
      .PGM_WR, .PGM_RD, .PGM_ERASE, .PGM_PROTECT, .PGM_RDATA, .PGM_RVALID,
      .PGM_REFUSED, .PGM_BUSY, .PROG_MODE, .PROTECT_ON);
   psv_pgm_model u_psv_pgm_model (.CLK, .PGM_ADDR, .PGM_WDATA, .PGM_WR,
      .PGM_RD, .PGM_ERASE, .PGM_PROTECT, .TEST, .PGM_BUSY);

   initial
   begin
      CLK = 1'b0;
      forever #12.5 CLK = ~CLK;
   end

   task chk(input string w, input logic [19:0] e, input logic [19:0] s);
      checks++;
      if (s !== e)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", w, e, s);
      end
   endtask : chk

   task end_of_test;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test

   function logic [11:0] vec(input logic [11:0] a);
      return {img[a + 12'h001][3:0], img[a]};
   endfunction : vec

   task wr(input logic [11:0] a, input logic [7:0] d);
      img[a] = d;
      u_psv_pgm_model.req(4'h4, a, d);
   endtask : wr

   // Six entries; a push onto a full stack replaces the top one
   task psh(input logic [11:0] r);
      if (stk.size() == STACK_DEPTH)
         stk[STACK_DEPTH-1] = r;
      else
         stk.push_back(r);
   endtask : psh

   // Kind: 0 advance, 1 jump, 2 call, 3 return, 4..7 interrupt, 8 edge pin
   task automatic core(input int k, input logic [11:0] t);
      logic e;
      e = k == 3 && stk.size() == 0;
      if (k == 2)
         psh(pc + 12'h001);
      if (k > 3)
         psh(pc);
      if (k == 3)
         pc = e ? pc : stk.pop_back();
      else if (k == 0)
         pc = pc + 12'h001;
      else if (k < 3)
         pc = t;
      else
         pc = vec(k == 8 ? VEC_NMI : VEC_IRQ_BASE + 12'(2 * (k - 4)));
      if (!e)
         opq.push_back({pc, img[pc]});
      // Drive in the idle cycle right after the fetch, as the checker expects
      CORE_TARGET  <= t;
      CORE_IRQ_SEL <= 2'(k - 4);
      if (k == 8)
         NMI_N <= 1'b0;
      else
         {CORE_IRQ, CORE_RET, CORE_CALL, CORE_JUMP, CORE_ADV} <=
            k > 3 ? 5'h10 : 5'(1 << k);
      @(posedge CLK);
      NMI_N <= 1'b1;
      {CORE_IRQ, CORE_RET, CORE_CALL, CORE_JUMP, CORE_ADV} <= 5'h00;
      do @(posedge CLK); while ((e ? STACK_ERR : OPCODE_VALID) !== 1'b1);
   endtask : core

   always @(negedge CLK)
   begin
      if (OPCODE_VALID === 1'b1)
         chk("fetch", opq.pop_front(), {PC_OUT, OPCODE});
      if (PGM_RVALID === 1'b1 || PGM_REFUSED === 1'b1)
         chk("pgm", 20'(pgq.pop_front()),
            {11'h000, PGM_REFUSED, PGM_REFUSED ? 8'h00 : PGM_RDATA});
      if (STACK_ERR === 1'b1)
         errs++;
   end

   always @(posedge CLK)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         mismatches++;
         end_of_test();
      end
   end

   initial
   begin
      void'($urandom(32'h3365B1E6));
      {CORE_IRQ, CORE_RET, CORE_CALL, CORE_JUMP, CORE_ADV} = 5'h00;
      CORE_TARGET  = 12'h000;
      CORE_IRQ_SEL = 2'h0;
      NMI_N        = 1'b1;
      RST_N        = 1'b0;
      u_psv_pgm_model.mode(1'b1);
      repeat (2) @(posedge CLK);
      RST_N <= 1'b1;
      repeat (6) @(posedge CLK);
      chk("prog_mode", 20'h1, 20'(PROG_MODE));
      u_psv_pgm_model.req(4'h1, 12'h000, 8'h00);
      pgq.push_back(9'h100);
      u_psv_pgm_model.req(4'h2, 12'h123, 8'h00);
      chk("protect", 20'h1, 20'(PROTECT_ON));
      u_psv_pgm_model.req(4'h8, 12'h000, 8'h00);
      chk("protect", 20'h0, 20'(PROTECT_ON));
      pgq.push_back({1'b0, FILL_VALUE});
      u_psv_pgm_model.req(4'h2, 12'h456, 8'h00);
      $display("test protect and erase done");
      foreach (img[a])
         img[a] = FILL_VALUE;
      u_psv_pgm_model.fill();
      for (int a = 12'h080; a < 12'hFA0; a++)
         wr(12'(a), 8'($urandom));
      for (int a = 0; a < 16; a += 2)
         if (a != 8 && a != 10)
         begin
            pc = 12'h080 + 12'($urandom % 3872);
            wr(VEC_IRQ_BASE + 12'(a), pc[7:0]);
            wr(VEC_IRQ_BASE + 12'(a + 1), {4'h0, pc[11:8]});
         end
      pgq.push_back({1'b0, img[VEC_RST]});
      u_psv_pgm_model.req(4'h2, VEC_RST, 8'h00);
      $display("test programming done");
      @(posedge CLK);
      RST_N <= 1'b0;
      u_psv_pgm_model.mode(1'b0);
      repeat (3) @(posedge CLK);
      pc = vec(VEC_RST);
      opq.push_back({pc, img[pc]});
      RST_N <= 1'b1;
      do @(posedge CLK); while (OPCODE_VALID !== 1'b1);
      chk("prog_mode", 20'h0, 20'(PROG_MODE));
      core(0, 12'h000);
      core(1, PC_LAST);
      core(0, 12'h000);
      for (int i = 4; i < 8; i++)
      begin
         core(i, 12'h000);
         core(3, 12'h000);
      end
      core(8, 12'h000);
      core(3, 12'h000);
      $display("test vectors done");
      repeat (7)
         core(2, 12'h080 + 12'($urandom % 3872));
      repeat (7)
         core(3, 12'h000);
      chk("stack_err", 20'h2, 20'(errs));
      // Every noted fetch and read must have been answered
      chk("queues", 20'h0, 20'(opq.size() + pgq.size()));
      $display("test stack done");
      end_of_test();
   end
endmodule : psv_core_tb

bind psv_core psv_core_monitor #(.DEPTH(DEPTH)) u_psv_core_monitor (.CLK,
   .RST_N, .NMI_N, .TEST, .CORE_ADV, .CORE_JUMP, .CORE_CALL, .CORE_RET,
   .CORE_IRQ, .PC_OUT, .OPCODE_VALID, .NMI_TAKEN, .STACK_ERR, .PGM_RD,
   .PGM_WR, .PGM_ERASE, .PGM_REFUSED, .PGM_BUSY, .PROG_MODE, .PROTECT_ON);

// file: sim/psv_pgm_model.sv
// Programmer model driving the programming port and test pin
`timescale 1ns/100ps
module psv_pgm_model import psv_pkg::*; (
   // Clock
   input  wire logic              CLK,
   // Requests
   output logic      [PC_W-1:0]   PGM_ADDR,
   output logic      [DATA_W-1:0] PGM_WDATA,
   output logic                   PGM_WR,
   output logic                   PGM_RD,
   output logic                   PGM_ERASE,
   output logic                   PGM_PROTECT,
   output logic                   TEST,
   // Answer
   input  wire logic              PGM_BUSY
);
   initial
   begin
      {PGM_ERASE, PGM_WR, PGM_RD, PGM_PROTECT} = 4'h0;
      PGM_ADDR  = 12'h000;
      PGM_WDATA = 8'h00;
      TEST      = 1'b0;
   end

   task mode(input logic t);
      TEST <= t;
   endtask : mode

   // Op is erase, write, read, protect from the top bit down
   task req(input logic [3:0] op, input logic [11:0] a, input logic [7:0] d);
      @(posedge CLK);
      {PGM_ERASE, PGM_WR, PGM_RD, PGM_PROTECT} <= op;
      PGM_ADDR  <= a;
      PGM_WDATA <= d;
      @(posedge CLK);
      {PGM_ERASE, PGM_WR, PGM_RD, PGM_PROTECT} <= 4'h0;
      // Released lines must not keep their last value
      PGM_ADDR  <= ~a;
      PGM_WDATA <= ~d;
      repeat (2) @(posedge CLK);
      while (PGM_BUSY === 1'b1)
         @(posedge CLK);
   endtask : req

   task fill;
      for (int a = 0; a < 4096; a++)
         if (a <= RSV_LOW_LAST || (a >= RSV_HI_FIRST && a <= RSV_HI_LAST)
             || (a >= RSV_MID_FIRST && a <= RSV_MID_LAST))
            req(4'h4, 12'(a), FILL_VALUE);
   endtask : fill
endmodule : psv_pgm_model

// file: verilog/psv_core.sv
// Program-space sequencer: vectors, return stack, programming port
`timescale 1ns/100ps
module psv_core import psv_pkg::*; #(
   parameter bit          ERASABLE = 1'b1,
   parameter int unsigned DEPTH    = STACK_DEPTH
)(
   // Clock and reset
   input  wire logic              CLK,
   input  wire logic              RST_N,
   // Asynchronous pins
   input  wire logic              NMI_N,
   input  wire logic              TEST,
   // Core requests
   input  wire logic              CORE_ADV,
   input  wire logic              CORE_JUMP,
   input  wire logic              CORE_CALL,
   input  wire logic              CORE_RET,
   input  wire logic [PC_W-1:0]   CORE_TARGET,
   input  wire logic              CORE_IRQ,
   input  wire logic [1:0]        CORE_IRQ_SEL,
   // Core answers
   output logic      [PC_W-1:0]   PC_OUT,
   output logic      [DATA_W-1:0] OPCODE,
   output logic                   OPCODE_VALID,
   output logic                   NMI_TAKEN,
   output logic                   STACK_ERR,
   // Programmer port
   input  wire logic [PC_W-1:0]   PGM_ADDR,
   input  wire logic [DATA_W-1:0] PGM_WDATA,
   input  wire logic              PGM_WR,
   input  wire logic              PGM_RD,
   input  wire logic              PGM_ERASE,
   input  wire logic              PGM_PROTECT,
   output logic      [DATA_W-1:0] PGM_RDATA,
   output logic                   PGM_RVALID,
   output logic                   PGM_REFUSED,
   output logic                   PGM_BUSY,
   output logic                   PROG_MODE,
   output logic                   PROTECT_ON
);
   localparam int unsigned SPW = $clog2(DEPTH + 1);

   psv_state_t        state_reg;
   psv_state_t        state_next;
   logic [PC_W-1:0]   pc_reg;
   logic [PC_W-1:0]   pc_next;
   logic              pc_load;
   logic [PC_W-1:0]   vec_reg;
   logic [PC_W-1:0]   vec_next;
   logic [DATA_W-1:0] lo_reg;
   logic [PC_W-1:0]   stk_reg [DEPTH];
   logic [SPW-1:0]    sp_reg;
   logic              push;
   logic              pop;
   logic [PC_W-1:0]   push_val;
   logic [PC_W-1:0]   stk_top;
   logic              stk_full;
   logic              stk_bad;
   logic              nmi_meta;
   logic              nmi_sync;
   logic              nmi_prev;
   logic              nmi_edge;
   logic              nmi_pend_reg;
   logic              take_nmi;
   logic              test_meta;
   logic              test_sync;
   logic [1:0]        settle_reg;
   logic [PC_W-1:0]   era_reg;
   logic              refuse;
   logic              mem_we;
   logic [PC_W-1:0]   mem_addr;
   logic [DATA_W-1:0] mem_wd;
   logic [DATA_W-1:0] mem_q;

   psv_mem #(
      .AW (PC_W),
      .DW (DATA_W)
   ) u_mem (
      .clk   (CLK),
      .rst_n (RST_N),
      .we    (mem_we),
      .addr  (mem_addr),
      .wdata (mem_wd),
      .rdata (mem_q)
   );

   // Pin synchronisers; first stages feed only the second
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         nmi_meta  <= 1'b1;
         nmi_sync  <= 1'b1;
         nmi_prev  <= 1'b1;
         test_meta <= 1'b0;
         test_sync <= 1'b0;
      end
      else
      begin
         nmi_meta  <= NMI_N;
         nmi_sync  <= nmi_meta;
         nmi_prev  <= nmi_sync;
         test_meta <= TEST;
         test_sync <= test_meta;
      end
   end

   assign nmi_edge = nmi_prev & ~nmi_sync;

   // Pending request; a new edge beats the clear
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         nmi_pend_reg <= 1'b0;
      end
      else if (nmi_edge)
      begin
         nmi_pend_reg <= 1'b1;
      end
      else if (take_nmi)
      begin
         nmi_pend_reg <= 1'b0;
      end
   end

   assign stk_full = (sp_reg == SPW'(DEPTH));
   assign stk_top  = stk_reg[SPW'(sp_reg - 1'b1)];

   always_comb
   begin
      state_next = state_reg;
      pc_next    = pc_reg;
      pc_load    = 1'b0;
      vec_next   = vec_reg;
      push       = 1'b0;
      pop        = 1'b0;
      push_val   = pc_reg;
      take_nmi   = 1'b0;
      stk_bad    = 1'b0;
      refuse     = 1'b0;
      mem_we     = 1'b0;
      mem_addr   = pc_reg;
      mem_wd     = FILL_VALUE;
      case (state_reg)
         S_RST:
         begin
            // Wait for the strap synchroniser to fill
            if (settle_reg == 2'(SETTLE_CYC))
            begin
               vec_next   = VEC_RST;
               state_next = test_sync ? S_PROG : S_VLO;
            end
         end
         S_VLO:
         begin
            mem_addr   = vec_reg;
            state_next = S_VHI;
         end
         S_VHI:
         begin
            mem_addr   = PC_W'(vec_reg + 12'h001);
            state_next = S_VEND;
         end
         S_VEND:
         begin
            pc_load    = 1'b1;
            pc_next    = {mem_q[3:0], lo_reg};
            state_next = S_FETCH;
         end
         S_FETCH:
         begin
            state_next = S_FDATA;
         end
         S_FDATA:
         begin
            state_next = S_RUN;
         end
         S_RUN:
         begin
            if (nmi_pend_reg)
            begin
               take_nmi   = 1'b1;
               push       = 1'b1;
               vec_next   = VEC_NMI;
               state_next = S_VLO;
            end
            else if (CORE_IRQ)
            begin
               push       = 1'b1;
               vec_next   = VEC_IRQ_BASE | {9'h000, CORE_IRQ_SEL, 1'b0};
               state_next = S_VLO;
            end
            else if (CORE_CALL)
            begin
               push       = 1'b1;
               push_val   = PC_W'(pc_reg + 12'h001);
               pc_load    = 1'b1;
               pc_next    = CORE_TARGET;
               state_next = S_FETCH;
            end
            else if (CORE_RET)
            begin
               if (sp_reg == '0)
               begin
                  stk_bad = 1'b1;
               end
               else
               begin
                  pop        = 1'b1;
                  pc_load    = 1'b1;
                  pc_next    = stk_top;
                  state_next = S_FETCH;
               end
            end
            else if (CORE_JUMP)
            begin
               pc_load    = 1'b1;
               pc_next    = CORE_TARGET;
               state_next = S_FETCH;
            end
            else if (CORE_ADV)
            begin
               pc_load    = 1'b1;
               pc_next    = PC_W'(pc_reg + 12'h001);
               state_next = S_FETCH;
            end
         end
         S_PROG:
         begin
            if (PGM_ERASE)
            begin
               if (ERASABLE)
               begin
                  state_next = S_ERASE;
               end
               else
               begin
                  refuse = 1'b1;
               end
            end
            else if (PGM_WR)
            begin
               mem_we   = 1'b1;
               mem_addr = PGM_ADDR;
               mem_wd   = PGM_WDATA;
            end
            else if (PGM_RD)
            begin
               mem_addr = PGM_ADDR;
               if (PROTECT_ON)
               begin
                  refuse = 1'b1;
               end
               else
               begin
                  state_next = S_PRD;
               end
            end
         end
         S_PRD:
         begin
            state_next = S_PROG;
         end
         S_ERASE:
         begin
            mem_we   = 1'b1;
            mem_addr = era_reg;
            mem_wd   = FILL_VALUE;
            if (era_reg == PC_LAST)
            begin
               state_next = S_PROG;
            end
         end
         default:
         begin
            state_next = S_RST;
         end
      endcase
   end

   // Held here for as long as the reset pin is low
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         state_reg  <= S_RST;
         settle_reg <= '0;
         vec_reg    <= VEC_RST;
         lo_reg     <= '0;
      end
      else
      begin
         state_reg <= state_next;
         vec_reg   <= vec_next;
         if (state_reg == S_RST)
         begin
            settle_reg <= 2'(settle_reg + 2'h1);
         end
         if (state_reg == S_VHI)
         begin
            lo_reg <= mem_q;
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         pc_reg <= PC_RESET;
      end
      else if (pc_load)
      begin
         pc_reg <= pc_next;
      end
   end

   // Full stack keeps the newest return; the oldest survive
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         sp_reg <= '0;
      end
      else if (push && !stk_full)
      begin
         sp_reg <= SPW'(sp_reg + 1'b1);
      end
      else if (pop)
      begin
         sp_reg <= SPW'(sp_reg - 1'b1);
      end
   end

   always_ff @(posedge CLK)
   begin
      if (push)
      begin
         if (stk_full)
         begin
            stk_reg[DEPTH-1] <= push_val;
         end
         else
         begin
            stk_reg[sp_reg] <= push_val;
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         PC_OUT       <= PC_RESET;
         OPCODE       <= OPCODE_RESET;
         OPCODE_VALID <= 1'b0;
         NMI_TAKEN    <= 1'b0;
         STACK_ERR    <= 1'b0;
      end
      else
      begin
         PC_OUT       <= pc_next;
         OPCODE_VALID <= (state_reg == S_FDATA);
         NMI_TAKEN    <= take_nmi;
         STACK_ERR    <= stk_bad | (push & stk_full);
         if (state_reg == S_FDATA)
         begin
            OPCODE <= mem_q;
         end
      end
   end

   // Protection is set by the programmer, cleared only by erase or reset
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         PROTECT_ON <= 1'b0;
      end
      else if (state_reg == S_ERASE && era_reg == PC_LAST)
      begin
         PROTECT_ON <= 1'b0;
      end
      else if (state_reg == S_PROG && PGM_PROTECT)
      begin
         PROTECT_ON <= 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         era_reg <= '0;
      end
      else if (state_reg == S_ERASE)
      begin
         era_reg <= PC_W'(era_reg + 12'h001);
      end
      else
      begin
         era_reg <= '0;
      end
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         PGM_RDATA   <= '0;
         PGM_RVALID  <= 1'b0;
         PGM_REFUSED <= 1'b0;
         PGM_BUSY    <= 1'b0;
         PROG_MODE   <= 1'b0;
      end
      else
      begin
         PGM_RVALID  <= (state_reg == S_PRD);
         PGM_REFUSED <= refuse;
         PGM_BUSY    <= (state_next == S_ERASE) || (state_next == S_PRD);
         PROG_MODE   <= (state_next == S_PROG) || (state_next == S_PRD)
                        || (state_next == S_ERASE);
         if (state_reg == S_PRD)
         begin
            PGM_RDATA <= mem_q;
         end
      end
   end
endmodule : psv_core

// file: verilog/psv_mem.sv
// Program memory array with registered read data
`timescale 1ns/100ps
module psv_mem #(
   parameter int unsigned AW = 12,
   parameter int unsigned DW = 8
)(
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rst_n,
   // Single port
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wdata,
   output logic      [DW-1:0] rdata
);
   logic [DW-1:0] mem_array [2**AW];

   // Array itself has no reset, like the real cells
   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem_array[addr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata <= '0;
      end
      else
      begin
         rdata <= mem_array[addr];
      end
   end
endmodule : psv_mem

// file: verilog/psv_pkg.sv
// Constants and types for the program-space sequencer
package psv_pkg;
   localparam int unsigned PC_W        = 12;
   localparam int unsigned DATA_W      = 8;
   localparam int unsigned STACK_DEPTH = 6;
   localparam int unsigned SETTLE_CYC  = 2;

   localparam logic [11:0] VEC_IRQ_BASE  = 12'hFF0;
   localparam logic [11:0] VEC_IRQ_LAST  = 12'hFF7;
   localparam logic [11:0] VEC_NMI       = 12'hFFC;
   localparam logic [11:0] VEC_RST       = 12'hFFE;
   localparam logic [11:0] RSV_LOW_FIRST = 12'h000;
   localparam logic [11:0] RSV_LOW_LAST  = 12'h07F;
   localparam logic [11:0] RSV_HI_FIRST  = 12'hFA0;
   localparam logic [11:0] RSV_HI_LAST   = 12'hFEF;
   localparam logic [11:0] RSV_MID_FIRST = 12'hFF8;
   localparam logic [11:0] RSV_MID_LAST  = 12'hFFB;
   localparam logic [11:0] PC_LAST       = 12'hFFF;
   localparam logic [11:0] PC_RESET      = 12'h000;
   localparam logic [7:0]  FILL_VALUE    = 8'hFF;
   localparam logic [7:0]  OPCODE_RESET  = 8'h00;

   typedef enum logic [3:0] {
      S_RST,
      S_VLO,
      S_VHI,
      S_VEND,
      S_FETCH,
      S_FDATA,
      S_RUN,
      S_PROG,
      S_PRD,
      S_ERASE
   } psv_state_t;
endpackage : psv_pkg
